// ===== design/ufl_pkg.sv
// package: register map, field layout and timing constants for the frame and list block
package ufl_pkg;
    localparam logic [31:0] UFL_IRQ_EN_ADDR = 32'hFFF0_5010;
    localparam logic [31:0] UFL_IRQ_DIS_ADDR = 32'hFFF0_5014;
    localparam logic [31:0] UFL_COMM_AREA_ADDR = 32'hFFF0_5018;
    localparam logic [31:0] UFL_PER_CUR_ADDR = 32'hFFF0_501C;
    localparam logic [31:0] UFL_CTL_HEAD_ADDR = 32'hFFF0_5020;
    localparam logic [31:0] UFL_CTL_CUR_ADDR = 32'hFFF0_5024;
    localparam logic [31:0] UFL_BLK_HEAD_ADDR = 32'hFFF0_5028;
    localparam logic [31:0] UFL_BLK_CUR_ADDR = 32'hFFF0_502C;
    localparam logic [31:0] UFL_DONE_HEAD_ADDR = 32'hFFF0_5030;
    localparam logic [31:0] UFL_FM_INTERVAL_ADDR = 32'hFFF0_5034;
    localparam logic [31:0] UFL_FM_REMAIN_ADDR = 32'hFFF0_5038;
    localparam logic [31:0] UFL_FM_NUMBER_ADDR = 32'hFFF0_503C;

    // interrupt enable bit positions
    localparam int UFL_GLOBAL_IRQ_BIT = 31;
    localparam int UFL_OWNER_CHG_BIT = 30;
    localparam int UFL_ROOT_HUB_BIT = 6;
    localparam int UFL_FRAME_OVF_BIT = 5;
    localparam int UFL_UNRECOV_BIT = 4;
    localparam int UFL_RESUME_BIT = 3;
    localparam int UFL_FRAME_START_BIT = 2;
    localparam int UFL_DONE_WB_BIT = 1;
    localparam int UFL_SCHED_OVR_BIT = 0;
    // writable enable bits; the unrecoverable-error enable is absent on purpose
    localparam logic [31:0] UFL_IRQ_EN_MASK = 32'hC000_006F;

    // pointer fields
    localparam int UFL_COMM_AREA_LSB = 8;
    localparam int UFL_DESC_LSB = 4;

    // frame interval layout
    localparam int UFL_INTERVAL_TOGGLE_BIT = 31;
    localparam int UFL_PACKET_LIMIT_MSB = 30;
    localparam int UFL_PACKET_LIMIT_LSB = 16;
    localparam int UFL_FRAME_LENGTH_MSB = 13;
    localparam int UFL_REMAIN_TOGGLE_BIT = 31;
    localparam logic [31:0] UFL_FM_INTERVAL_RESET = 32'h0000_2EDF;
    localparam logic [31:0] UFL_FM_INTERVAL_MASK = 32'hFFFF_3FFF;
    localparam logic [31:0] UFL_ZERO_RESET = 32'h0000_0000;

    // functional state encoding from the control logic
    localparam logic [1:0] UFL_STATE_OPERATIONAL = 2'b10;

    // bit clock derived from mclk by a phase accumulator
    localparam int UFL_MCLK_KHZ = 250_000;
    localparam int UFL_BIT_KHZ = 12_000;
    localparam int UFL_PHASE_W = 18;

    // list processor pointer selects
    localparam logic [2:0] UFL_SEL_PER_CUR = 3'h0;
    localparam logic [2:0] UFL_SEL_CTL_CUR = 3'h1;
    localparam logic [2:0] UFL_SEL_BLK_CUR = 3'h2;
    localparam logic [2:0] UFL_SEL_DONE_HEAD = 3'h3;
    localparam logic [2:0] UFL_SEL_CTL_HEAD = 3'h4;
    localparam logic [2:0] UFL_SEL_BLK_HEAD = 3'h5;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ufl_bus_req_type;

    typedef struct packed {
        logic [27:0] sel_ptr;
        logic [2:0] sel;
        logic wr;
    } ufl_lp_upd_type;

    typedef struct packed {
        logic [23:0] comm_area;
        logic [27:0] periodic_current_ptr;
        logic [27:0] control_head_ptr;
        logic [27:0] control_current_ptr;
        logic [27:0] bulk_head_ptr;
        logic [27:0] bulk_current_ptr;
        logic [27:0] done_head_ptr;
    } ufl_ptrs_type;

    typedef struct packed {
        logic [15:0] frame_count_value;
        logic [13:0] remaining_time_count;
        logic remaining_toggle;
        logic [14:0] largest_packet_count;
        logic frame_start;
        logic frame_overflow;
    } ufl_frame_type;

    typedef enum logic [1:0] {
        UFL_FRM_STOP = 2'b01,
        UFL_FRM_RUN = 2'b10
    } ufl_frm_state_type;
endpackage

// ===== design/ufl_frame_list_regs.sv
// frame timing, interrupt enable/disable and list pointer registers of the usb host
//
// Contract
// - writing one to disable bit 31 clears the global interrupt enable
// - disable bits 30,6,5,3,2,1,0 clear their matching interrupt enables
// - zero bits written to the disable register leave enables unchanged
// - unrecoverable-error enable ignores every write, reads zero
// - comm area pointer held in bits 31:8, bits 7:0 reserved
// - periodic current pointer in bits 31:4, low bits read zero
// - control head pointer in bits 31:4, low bits reserved
// - control current pointer in bits 31:4, low bits read zero
// - bulk head pointer in bits 31:4, low bits read zero
// - bulk current pointer in bits 31:4, low bits read zero
// - done head pointer in bits 31:4, low bits read zero
// - largest packet counter loads from bits 30:16 at each frame start
// - remaining toggle copies interval toggle whenever remaining count loads
// - remaining count decrements once per 12 MHz period while operational
// - remaining count reloads from frame length on reaching zero
// - remaining count loads on entry into operational state
// - frame remaining register is read-only, resets to zero
// - frame number register is read-only, resets to zero
// - frame number increments on each remaining load, wraps to zero
module ufl_frame_list_regs
    import ufl_pkg::*;
#(
    parameter int MCLK_KHZ = UFL_MCLK_KHZ,
    parameter int BIT_KHZ = UFL_BIT_KHZ
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire ufl_bus_req_type bus_i,
    output logic [31:0] rdata_o,
    input wire logic [1:0] hc_state_i,
    input wire ufl_lp_upd_type lp_i,
    output logic [31:0] irq_enable_o,
    output ufl_ptrs_type ptrs_o,
    output ufl_frame_type frame_o
);
    localparam logic [UFL_PHASE_W-1:0] PHASE_STEP = UFL_PHASE_W'(BIT_KHZ);
    localparam logic [UFL_PHASE_W-1:0] PHASE_WRAP = UFL_PHASE_W'(MCLK_KHZ);

    function automatic logic hit(input ufl_bus_req_type b, input logic [31:0] a);
        return b.addr == a;
    endfunction

    function automatic logic [31:0] desc_word(input logic [27:0] p);
        return {p, 4'h0};
    endfunction

    logic [31:0] irq_en_reg;
    logic [23:0] comm_area_reg;
    logic [27:0] per_cur_reg;
    logic [27:0] ctl_head_reg;
    logic [27:0] ctl_cur_reg;
    logic [27:0] blk_head_reg;
    logic [27:0] blk_cur_reg;
    logic [27:0] done_head_reg;
    logic [31:0] fm_interval_reg;
    logic [13:0] remain_reg;
    logic remain_toggle_reg;
    logic [15:0] frame_num_reg;
    logic [14:0] ldp_count_reg;
    logic sof_reg;
    logic fno_reg;
    logic [UFL_PHASE_W-1:0] phase_reg;
    logic bit_tick_reg;
    logic [31:0] rdata_reg;
    ufl_frm_state_type frm_state_reg;
    ufl_frm_state_type frm_state_next;

    logic operational;
    logic frame_load;
    logic [UFL_PHASE_W-1:0] phase_sum;
    logic [15:0] frame_num_next;

    assign operational = hc_state_i == UFL_STATE_OPERATIONAL;
    assign phase_sum = phase_reg + PHASE_STEP;
    assign frame_num_next = frame_num_reg + 16'h0001;

    // interrupt enables: set register sets, disable register clears
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_reg <= UFL_ZERO_RESET;
        end else if (bus_i.wr && hit(bus_i, UFL_IRQ_EN_ADDR)) begin
            irq_en_reg <= (irq_en_reg | bus_i.wdata) & UFL_IRQ_EN_MASK;
        end else if (bus_i.wr && hit(bus_i, UFL_IRQ_DIS_ADDR)) begin
            // only ones clear; zeros and the error enable stay as they are
            irq_en_reg <= irq_en_reg & ~(bus_i.wdata & UFL_IRQ_EN_MASK);
        end
    end

    // communication area base
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            comm_area_reg <= UFL_ZERO_RESET[31:UFL_COMM_AREA_LSB];
        end else if (bus_i.wr && hit(bus_i, UFL_COMM_AREA_ADDR)) begin
            comm_area_reg <= bus_i.wdata[31:UFL_COMM_AREA_LSB];
        end
    end

    // descriptor pointers; a list processor update wins over a software write
    // in the same cycle so that hardware progress is never lost
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            per_cur_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
            ctl_head_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
            ctl_cur_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
            blk_head_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
            blk_cur_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
            done_head_reg <= UFL_ZERO_RESET[31:UFL_DESC_LSB];
        end else begin
            if (lp_i.wr && lp_i.sel == UFL_SEL_PER_CUR) begin
                per_cur_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_PER_CUR_ADDR)) begin
                per_cur_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
            if (lp_i.wr && lp_i.sel == UFL_SEL_CTL_HEAD) begin
                ctl_head_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_CTL_HEAD_ADDR)) begin
                ctl_head_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
            if (lp_i.wr && lp_i.sel == UFL_SEL_CTL_CUR) begin
                ctl_cur_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_CTL_CUR_ADDR)) begin
                ctl_cur_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
            if (lp_i.wr && lp_i.sel == UFL_SEL_BLK_HEAD) begin
                blk_head_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_BLK_HEAD_ADDR)) begin
                blk_head_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
            if (lp_i.wr && lp_i.sel == UFL_SEL_BLK_CUR) begin
                blk_cur_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_BLK_CUR_ADDR)) begin
                blk_cur_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
            if (lp_i.wr && lp_i.sel == UFL_SEL_DONE_HEAD) begin
                done_head_reg <= lp_i.sel_ptr;
            end else if (bus_i.wr && hit(bus_i, UFL_DONE_HEAD_ADDR)) begin
                done_head_reg <= bus_i.wdata[31:UFL_DESC_LSB];
            end
        end
    end

    // frame interval; toggle discipline is software's job, bits 15:14 dropped, rest stored as written
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fm_interval_reg <= UFL_FM_INTERVAL_RESET;
        end else if (bus_i.wr && hit(bus_i, UFL_FM_INTERVAL_ADDR)) begin
            fm_interval_reg <= bus_i.wdata & UFL_FM_INTERVAL_MASK;
        end
    end

    // 12 MHz bit tick from 250 MHz: fractional accumulator, jitter of one mclk
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg <= '0;
            bit_tick_reg <= 1'b0;
        end else if (phase_sum >= PHASE_WRAP) begin
            phase_reg <= phase_sum - PHASE_WRAP;
            bit_tick_reg <= 1'b1;
        end else begin
            phase_reg <= phase_sum;
            bit_tick_reg <= 1'b0;
        end
    end

    always_comb begin
        frm_state_next = frm_state_reg;
        frame_load = 1'b0;
        case (frm_state_reg)
            UFL_FRM_STOP: begin
                if (operational) begin
                    frm_state_next = UFL_FRM_RUN;
                    frame_load = 1'b1;
                end
            end
            UFL_FRM_RUN: begin
                if (!operational) begin
                    frm_state_next = UFL_FRM_STOP;
                end else if (bit_tick_reg && remain_reg == 14'h0000) begin
                    frame_load = 1'b1;
                end
            end
            default: begin
                frm_state_next = UFL_FRM_STOP;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frm_state_reg <= UFL_FRM_STOP;
        end else begin
            frm_state_reg <= frm_state_next;
        end
    end

    // remaining-time counter and its toggle
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            remain_reg <= UFL_ZERO_RESET[13:0];
            remain_toggle_reg <= 1'b0;
        end else if (frame_load) begin
            remain_reg <= fm_interval_reg[UFL_FRAME_LENGTH_MSB:0];
            remain_toggle_reg <= fm_interval_reg[UFL_INTERVAL_TOGGLE_BIT];
        end else if (frm_state_reg == UFL_FRM_RUN && operational && bit_tick_reg) begin
            remain_reg <= remain_reg - 14'h0001;
        end
    end

    // frame number and overflow event on a change of bit 15
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_num_reg <= UFL_ZERO_RESET[15:0];
            fno_reg <= 1'b0;
        end else if (frame_load) begin
            frame_num_reg <= frame_num_next;
            fno_reg <= frame_num_next[15] != frame_num_reg[15];
        end else begin
            fno_reg <= 1'b0;
        end
    end

    // largest data packet counter, reloaded per frame, counts bit times down
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ldp_count_reg <= '0;
            sof_reg <= 1'b0;
        end else begin
            sof_reg <= frame_load;
            if (frame_load) begin
                ldp_count_reg <= fm_interval_reg[UFL_PACKET_LIMIT_MSB:UFL_PACKET_LIMIT_LSB];
            end else if (bit_tick_reg && operational && ldp_count_reg != 15'h0000) begin
                ldp_count_reg <= ldp_count_reg - 15'h0001;
            end
        end
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped addresses
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= UFL_ZERO_RESET;
        end else if (!bus_i.rd) begin
            rdata_reg <= UFL_ZERO_RESET;
        end else begin
            case (bus_i.addr)
                UFL_IRQ_EN_ADDR: rdata_reg <= irq_en_reg;
                UFL_IRQ_DIS_ADDR: rdata_reg <= irq_en_reg;
                UFL_COMM_AREA_ADDR: rdata_reg <= {comm_area_reg, 8'h00};
                UFL_PER_CUR_ADDR: rdata_reg <= desc_word(per_cur_reg);
                UFL_CTL_HEAD_ADDR: rdata_reg <= desc_word(ctl_head_reg);
                UFL_CTL_CUR_ADDR: rdata_reg <= desc_word(ctl_cur_reg);
                UFL_BLK_HEAD_ADDR: rdata_reg <= desc_word(blk_head_reg);
                UFL_BLK_CUR_ADDR: rdata_reg <= desc_word(blk_cur_reg);
                UFL_DONE_HEAD_ADDR: rdata_reg <= desc_word(done_head_reg);
                UFL_FM_INTERVAL_ADDR: rdata_reg <= fm_interval_reg;
                UFL_FM_REMAIN_ADDR: begin
                    rdata_reg <= {remain_toggle_reg, 17'h0_0000, remain_reg};
                end
                UFL_FM_NUMBER_ADDR: rdata_reg <= {16'h0000, frame_num_reg};
                default: rdata_reg <= UFL_ZERO_RESET;
            endcase
        end
    end

    assign rdata_o = rdata_reg;
    assign irq_enable_o = irq_en_reg;
    assign ptrs_o.comm_area = comm_area_reg;
    assign ptrs_o.periodic_current_ptr = per_cur_reg;
    assign ptrs_o.control_head_ptr = ctl_head_reg;
    assign ptrs_o.control_current_ptr = ctl_cur_reg;
    assign ptrs_o.bulk_head_ptr = blk_head_reg;
    assign ptrs_o.bulk_current_ptr = blk_cur_reg;
    assign ptrs_o.done_head_ptr = done_head_reg;
    assign frame_o.frame_count_value = frame_num_reg;
    assign frame_o.remaining_time_count = remain_reg;
    assign frame_o.remaining_toggle = remain_toggle_reg;
    assign frame_o.largest_packet_count = ldp_count_reg;
    assign frame_o.frame_start = sof_reg;
    assign frame_o.frame_overflow = fno_reg;
endmodule // ufl_frame_list_regs

// ===== testbench/ufl_ctl_model.sv
// stand-in for the control logic and list processor beside the block
module ufl_ctl_model
    import ufl_pkg::*;
(
    input wire logic mclk_i,
    output logic [1:0] hc_state_o,
    output ufl_lp_upd_type lp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        hc_state_o = 2'b00;
        lp_o = '0;
    end
    task automatic set_state(input logic [1:0] s);
        @(posedge mclk_i);
        hc_state_o <= s;
    endtask
    task automatic lp_write(input logic [2:0] sel, input logic [27:0] p);
        @(posedge mclk_i);
        lp_o <= '{sel_ptr: p, sel: sel, wr: 1'b1};
        @(posedge mclk_i);
        // released pointer shows garbage, not the last value
        lp_o <= '{sel_ptr: ~p, sel: sel, wr: 1'b0};
    endtask
endmodule // ufl_ctl_model

// ===== testbench/ufl_frame_list_regs_assertions.sv
// port-level checks of the frame and list register block
module ufl_frame_list_regs_assertions
    import ufl_pkg::*;
#(
    parameter int MCLK_KHZ = UFL_MCLK_KHZ,
    parameter int BIT_KHZ = UFL_BIT_KHZ
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire ufl_bus_req_type bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] hc_state_i,
    input wire ufl_lp_upd_type lp_i,
    input wire logic [31:0] irq_enable_o,
    input wire ufl_ptrs_type ptrs_o,
    input wire ufl_frame_type frame_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_dis_wr;
        bus_i.wr && bus_i.addr == UFL_IRQ_DIS_ADDR;
    endsequence
    sequence s_load;
        $changed(frame_o.frame_count_value);
    endsequence
    AST_RDATA_IDLE: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside read slot");
    AST_GLOBAL_OFF: assert property (s_dis_wr ##0 bus_i.wdata[31] |=> !irq_enable_o[31])
        else $error("global enable survived disable write");
    AST_DIS_MASK: assert property (s_dis_wr |=>
        irq_enable_o == ($past(irq_enable_o) & ~$past(bus_i.wdata)))
        else $error("disable write gave wrong enables");
    AST_UNRECOV_ZERO: assert property ((irq_enable_o & ~UFL_IRQ_EN_MASK) == 32'h0000_0000)
        else $error("unimplemented enable bit set");
    AST_COMM_PTR: assert property (bus_i.wr && bus_i.addr == UFL_COMM_AREA_ADDR |=>
        ptrs_o.comm_area == $past(bus_i.wdata[31:8]))
        else $error("comm area pointer not written");
    AST_CTL_HEAD: assert property (bus_i.wr && bus_i.addr == UFL_CTL_HEAD_ADDR
        && !(lp_i.wr && lp_i.sel == UFL_SEL_CTL_HEAD)
        |=> ptrs_o.control_head_ptr == $past(bus_i.wdata[31:4]))
        else $error("control head pointer not written");
    AST_NUM_STEP: assert property (s_load |->
        frame_o.frame_count_value == 16'($past(frame_o.frame_count_value) + 16'h0001))
        else $error("frame number did not step by one");
    AST_TOGGLE_AT_LOAD: assert property ($changed(frame_o.remaining_toggle) |-> s_load)
        else $error("remaining toggle moved without a load");
    AST_HOLD_STOPPED: assert property ($past(hc_state_i) != UFL_STATE_OPERATIONAL |->
        $stable(frame_o.remaining_time_count) && $stable(frame_o.frame_count_value))
        else $error("frame counters moved while not operational");
    AST_RELOAD_START: assert property ($changed(frame_o.remaining_time_count)
        && frame_o.remaining_time_count != 14'($past(frame_o.remaining_time_count) - 14'h0001)
        |-> ##[0:1] frame_o.frame_start)
        else $error("remaining reload without frame start");
    AST_LOAD_START: assert property (s_load |-> ##[0:1] frame_o.frame_start)
        else $error("frame number load without frame start");
endmodule // ufl_frame_list_regs_assertions

bind ufl_frame_list_regs ufl_frame_list_regs_assertions #(
    .MCLK_KHZ(MCLK_KHZ),
    .BIT_KHZ(BIT_KHZ)
) u_ufl_frame_list_regs_assertions (
    .mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .hc_state_i(hc_state_i), .lp_i(lp_i), .irq_enable_o(irq_enable_o),
    .ptrs_o(ptrs_o), .frame_o(frame_o)
);

// ===== testbench/usb_host_frame_and_list_regs_tb.sv
// self-checking bench for the frame timing and list pointer register block
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module usb_host_frame_and_list_regs_tb
    import ufl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // a bit tick every mclk keeps the full frame number wrap short
    localparam int BIT_KHZ = 250_000;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    ufl_bus_req_type bus_i = '0;
    logic [31:0] rdata_o;
    logic [1:0] hc_state_i;
    ufl_lp_upd_type lp_i;
    logic [31:0] irq_enable_o;
    ufl_ptrs_type ptrs_o;
    ufl_frame_type frame_o;
    int bad_count = 0;
    int checks_done = 0;
    int starts = 0;
    int ovfs = 0;
    always #2 mclk_i = ~mclk_i;
    ufl_frame_list_regs #(.BIT_KHZ(BIT_KHZ)) u_ufl_frame_list_regs (
        .mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .hc_state_i(hc_state_i), .lp_i(lp_i), .irq_enable_o(irq_enable_o),
        .ptrs_o(ptrs_o), .frame_o(frame_o));
    ufl_ctl_model u_ufl_ctl_model (.mclk_i(mclk_i), .hc_state_o(hc_state_i), .lp_o(lp_i));
    always @(posedge mclk_i) begin
        if (frame_o.frame_start === 1'b1) starts++;
        if (frame_o.frame_overflow === 1'b1) ovfs++;
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus_i.rd <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask
    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            #1 n++;
        end while (frame_o.frame_start !== 1'b1 && n < 50);
        // a frame start that never comes is a failure, not a silent return
        if (frame_o.frame_start !== 1'b1) bad_count++;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 12; i++) begin
            rd(32'hFFF0_5010 + 32'(4 * i), i == 9 ? 32'h0000_2EDF : 32'h0000_0000);
        end
    endtask
    task automatic t_ptrs;
        // register reached by each list processor select, in select order
        logic [31:0] lp_addr [6] = '{UFL_PER_CUR_ADDR, UFL_CTL_CUR_ADDR, UFL_BLK_CUR_ADDR,
            UFL_DONE_HEAD_ADDR, UFL_CTL_HEAD_ADDR, UFL_BLK_HEAD_ADDR};
        for (int i = 2; i < 9; i++) begin
            wr(32'hFFF0_5010 + 32'(4 * i), 32'hFFFF_FFFF);
            rd(32'hFFF0_5010 + 32'(4 * i), i == 2 ? 32'hFFFF_FF00 : 32'hFFFF_FFF0);
        end
        `CHK(ptrs_o, {24'hFF_FFFF, {6{28'hFFF_FFFF}}})
        wr(UFL_FM_REMAIN_ADDR, 32'hFFFF_FFFF);
        rd(UFL_FM_REMAIN_ADDR, 32'h0000_0000);
        wr(UFL_FM_NUMBER_ADDR, 32'hFFFF_FFFF);
        rd(UFL_FM_NUMBER_ADDR, 32'h0000_0000);
        rd(32'hFFF0_5080, 32'h0000_0000);
        foreach (lp_addr[s]) begin
            u_ufl_ctl_model.lp_write(3'(s), 28'h123_4560 + 28'(s));
            rd(lp_addr[s], 32'h1234_5600 + 32'(16 * s));
        end
    endtask
    task automatic t_irq;
        int bits [8] = '{31, 30, 6, 5, 3, 2, 1, 0};
        logic [31:0] en;
        en = 32'hC000_006F;
        wr(UFL_IRQ_EN_ADDR, 32'hFFFF_FFFF);
        rd(UFL_IRQ_EN_ADDR, en);
        wr(UFL_IRQ_DIS_ADDR, 32'h0000_0000);
        rd(UFL_IRQ_DIS_ADDR, en);
        foreach (bits[i]) begin
            // bit 4 rides along to show it stays dead
            wr(UFL_IRQ_DIS_ADDR, (32'h0000_0001 << bits[i]) | 32'h0000_0010);
            en[bits[i]] = 1'b0;
            rd(UFL_IRQ_DIS_ADDR, en);
        end
        rd(UFL_IRQ_EN_ADDR, 32'h0000_0000);
    endtask
    task automatic t_frame;
        int n;
        wr(UFL_FM_INTERVAL_ADDR, 32'hC123_C005);
        rd(UFL_FM_INTERVAL_ADDR, 32'hC123_0005);
        u_ufl_ctl_model.set_state(UFL_STATE_OPERATIONAL);
        wait_start(n);
        `CHK(frame_o.frame_count_value, 16'h0001)
        `CHK(frame_o.remaining_toggle, 1'b1)
        `CHK(frame_o.largest_packet_count - 15'(frame_o.remaining_time_count), 15'h411E)
        wait_start(n);
        `CHK(n, 6)
        wr(UFL_FM_INTERVAL_ADDR, 32'h4123_0005);
        wait_start(n);
        wait_start(n);
        `CHK(frame_o.remaining_toggle, 1'b0)
        u_ufl_ctl_model.set_state(2'b00);
        repeat (4) @(posedge mclk_i);
        rd(UFL_FM_NUMBER_ADDR, 32'(starts));
    endtask
    task automatic t_wrap;
        int i;
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        starts = 0;
        ovfs = 0;
        rst_i <= 1'b0;
        wr(UFL_FM_INTERVAL_ADDR, 32'h0000_0000);
        u_ufl_ctl_model.set_state(UFL_STATE_OPERATIONAL);
        i = 0;
        do begin
            @(posedge mclk_i);
            #1 i++;
        end while (frame_o.frame_count_value !== 16'hFFFF && i < 70_000);
        `CHK(frame_o.frame_count_value, 16'hFFFF)
        u_ufl_ctl_model.set_state(2'b00);
        repeat (4) @(posedge mclk_i);
        rd(UFL_FM_NUMBER_ADDR, 32'(starts % 65536));
        `CHK(ovfs, 2)
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        // frame wrap needs about 66k cycles, the rest a few hundred
        #(90_000 * 4);
        bad_count++;
        results;
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_reset;
        t_ptrs;
        t_irq;
        t_frame;
        t_wrap;
        results;
    end
endmodule // usb_host_frame_and_list_regs_tb
